// ---- bar_hit_decode.sv ----
// base address compare: one-hot hit lines for the memory and i/o windows
// assumes address and command are already registered by the caller
`timescale 1ns/1ps
module bar_hit_decode (
    // address phase contents
    input wire logic [31:0] addr_in,
    input wire logic [3:0] cmd_in,
    // window bases and space enables
    input wire logic [31:0] mem_base_in,
    input wire logic [31:0] io_base_in,
    input wire pci_user_pkg::enables_type enables_in,
    // result
    output logic [7:0] hit_out
);

    function automatic logic is_mem_cmd(input logic [3:0] cmd);
        is_mem_cmd = (cmd == pci_user_pkg::CMD_MEM_READ) ||
                     (cmd == pci_user_pkg::CMD_MEM_WRITE) ||
                     (cmd == pci_user_pkg::CMD_MEM_READ_MULT) ||
                     (cmd == pci_user_pkg::CMD_MEM_READ_LINE) ||
                     (cmd == pci_user_pkg::CMD_MEM_WRITE_INV);
    endfunction : is_mem_cmd

    always_comb begin
        hit_out = pci_user_pkg::HIT_RESET;
        hit_out[pci_user_pkg::HIT_MEM_LINE] = enables_in.memory && is_mem_cmd(cmd_in) &&
            ((addr_in & pci_user_pkg::BAR_MEM_MASK) ==
             (mem_base_in & pci_user_pkg::BAR_MEM_MASK));
        hit_out[pci_user_pkg::HIT_IO_LINE] = enables_in.io &&
            ((cmd_in == pci_user_pkg::CMD_IO_READ) || (cmd_in == pci_user_pkg::CMD_IO_WRITE)) &&
            ((addr_in & pci_user_pkg::BAR_IO_MASK) ==
             (io_base_in & pci_user_pkg::BAR_IO_MASK));
    end

endmodule : bar_hit_decode

// ---- pci_user_app.sv ----
// user application model: ready pacing, termination and internal bus data
// assumes the same pci clock as pci_user_side and the bench's mode select
`timescale 1ns/1ps
module pci_user_app (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // mode 0 prompt, 1 slow, 2 retry
    input wire logic [1:0] mode_in,
    input wire logic strobe_in,
    input wire logic cfg_read_in,
    // answers
    output logic ready_out,
    output logic term_out,
    output logic [31:0] bus_data_out
);
    logic [2:0] wait_cnt;
    logic [31:0] word;
    always_ff @(posedge clk_in) begin
        if (rst_in || strobe_in) begin
            wait_cnt <= 3'h0;
        end else if (wait_cnt != 3'h6) begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
    always_ff @(posedge clk_in) begin
        word <= rst_in ? 32'hc0de_0000 : word + 32'h0001_0001;
    end
    assign ready_out = (mode_in == 2'h0) || (mode_in == 2'h1 && wait_cnt == 3'h6);
    assign term_out = (mode_in == 2'h2);
    // released on config read
    // a released bus shows a moving inverse, never the last word
    assign bus_data_out = cfg_read_in ? ~word : word;
endmodule : pci_user_app

// ---- pci_user_pkg.sv ----
// constants, state encodings and carrier structs for the pci user-side bridge
// assumes a single pci clock domain and a synchronous active-high reset
package pci_user_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int PCI_MAX_CLK_MHZ = 33;

    ////////////////////////////////////////////////////////////////////////////
    // bus commands on cbe during the address phase
    localparam logic [3:0] CMD_IO_READ = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE = 4'h3;
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;

    ////////////////////////////////////////////////////////////////////////////
    // base address decode
    localparam int HIT_LINES = 8;
    localparam int HIT_MEM_LINE = 0;
    localparam int HIT_IO_LINE = 1;
    localparam logic [31:0] BAR_MEM_MASK = 32'hfff0_0000;
    localparam logic [31:0] BAR_IO_MASK = 32'hffff_ff00;

    ////////////////////////////////////////////////////////////////////////////
    // timing and reset values
    localparam logic [2:0] DEVSEL_WAIT_CYCLES = 3'h5;
    localparam logic [2:0] DEVSEL_COUNT_RESET = 3'h0;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [3:0] CBE_RESET = 4'h0;
    localparam logic [15:0] CMD_DECODE_RESET = 16'h0000;
    localparam logic [7:0] HIT_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    // pin-level cycle control, active low as on the bus
    typedef struct packed {
        logic frame;
        logic irdy;
        logic trdy;
        logic stop;
        logic devsel;
    } ctrl_pins_type;

    // registered cycle control for the user, active high (1 = asserted)
    typedef struct packed {
        logic frame;
        logic irdy;
        logic trdy;
        logic stop;
        logic devsel;
        logic perr;
    } cycle_ctrl_type;

    typedef struct packed {
        logic bus_master;
        logic memory;
        logic io;
    } enables_type;

    typedef enum logic [2:0] {
        T_IDLE = 3'b000,
        T_DECODE = 3'b001,
        T_BUSY = 3'b010,
        T_DATA = 3'b011,
        T_TURN = 3'b100
    } target_state_type;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_ADDR = 2'b01,
        M_DATA = 2'b10,
        M_TURN = 2'b11
    } initiator_state_type;

endpackage : pci_user_pkg

// ---- pci_user_side.sv ----
// pci user-side bridge: target and initiator sequencing, bus parking and the
// registered strobes, command and address that the user application sees
// assumes pins are synchronous to clk_sys_in and the pad wire is resolved outside
`timescale 1ns/1ps

module pci_user_side (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // pci cycle control pins, active low
    input wire pci_user_pkg::ctrl_pins_type ctrl_n_in,
    output pci_user_pkg::ctrl_pins_type ctrl_n_out,
    output pci_user_pkg::ctrl_pins_type ctrl_oe_out,
    input wire logic perr_n_in,
    // pci address/data and command pins
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe_out,
    input wire logic [3:0] cbe_in,
    output logic [3:0] cbe_out,
    output logic cbe_oe_out,
    // arbitration and selection
    input wire logic gnt_n_in,
    output logic req_n_out,
    input wire logic idsel_in,
    // command register enables and window bases from configuration space
    input wire pci_user_pkg::enables_type enables_in,
    input wire logic [31:0] mem_base_in,
    input wire logic [31:0] io_base_in,
    // user initiator controls
    input wire logic user_request_in,
    input wire logic user_complete_in,
    input wire logic [3:0] m_cbe_in,
    input wire logic m_wrdn_in,
    // user data-flow controls
    input wire logic user_ready_in,
    input wire logic user_term_in,
    // internal address/data bus
    input wire logic [31:0] internal_addr_data_bus_in,
    output logic [31:0] internal_addr_data_bus_out,
    output logic internal_addr_data_bus_oe_out,
    // user strobes and latched information
    output logic address_phase_strobe_out,
    output logic transfer_done_strobe_out,
    output logic config_cycle_hint_out,
    output logic target_direction_out,
    output logic [3:0] target_cmd_byte_enables_out,
    output logic [15:0] cmd_decode_out,
    output logic [31:0] latched_addr_out,
    output logic [7:0] base_hit_out,
    output pci_user_pkg::cycle_ctrl_type cycle_ctrl_out
);

    function automatic logic [15:0] one_hot16(input logic [3:0] code);
        one_hot16 = 16'h0001 << code;
    endfunction : one_hot16

    ////////////////////////////////////////////////////////////////////////////
    // input registers

    pci_user_pkg::target_state_type t_state;
    pci_user_pkg::initiator_state_type i_state;
    logic [31:0] ad_q;
    logic [3:0] cbe_q;
    logic frame_prev;
    logic idsel_q;
    logic [7:0] hit;
    logic [7:0] hit_reg;
    logic stop_drive;
    logic last_phase;
    logic m_dir;
    logic parking;
    logic [2:0] devsel_count;
    logic addr_strobe;
    logic xfer;
    logic bus_idle;
    logic start_ok;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            cycle_ctrl_out <= '0;
            frame_prev <= 1'b0;
            idsel_q <= 1'b0;
            ad_q <= pci_user_pkg::ADDR_RESET;
            cbe_q <= pci_user_pkg::CBE_RESET;
        end else begin
            cycle_ctrl_out.frame <= ~ctrl_n_in.frame;
            cycle_ctrl_out.irdy <= ~ctrl_n_in.irdy;
            cycle_ctrl_out.trdy <= ~ctrl_n_in.trdy;
            cycle_ctrl_out.stop <= ~ctrl_n_in.stop;
            cycle_ctrl_out.devsel <= ~ctrl_n_in.devsel;
            cycle_ctrl_out.perr <= ~perr_n_in;
            frame_prev <= cycle_ctrl_out.frame;
            idsel_q <= idsel_in;
            ad_q <= ad_in;
            cbe_q <= cbe_in;
        end
    end

    assign addr_strobe = cycle_ctrl_out.frame && !frame_prev;
    assign xfer = !ctrl_n_in.irdy && !ctrl_n_in.trdy;
    assign bus_idle = ctrl_n_in.frame && ctrl_n_in.irdy;
    assign start_ok = !gnt_n_in && user_request_in && enables_in.bus_master && bus_idle &&
                      (i_state == pci_user_pkg::M_IDLE) && (t_state == pci_user_pkg::T_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // address phase capture

    bar_hit_decode u_bar_hit_decode (
        .addr_in(ad_q),
        .cmd_in(cbe_q),
        .mem_base_in(mem_base_in),
        .io_base_in(io_base_in),
        .enables_in(enables_in),
        .hit_out(hit)
    );

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            latched_addr_out <= pci_user_pkg::ADDR_RESET;
            cmd_decode_out <= pci_user_pkg::CMD_DECODE_RESET;
            target_direction_out <= 1'b0;
            hit_reg <= pci_user_pkg::HIT_RESET;
        end else if (addr_strobe) begin
            latched_addr_out <= ad_q;
            cmd_decode_out <= one_hot16(cbe_q);
            target_direction_out <= cbe_q[0];
            // own initiator cycles are never claimed by the target
            hit_reg <= (i_state == pci_user_pkg::M_IDLE) ? hit : pci_user_pkg::HIT_RESET;
        end
    end

    assign target_cmd_byte_enables_out = cbe_q;
    assign address_phase_strobe_out = addr_strobe;
    assign config_cycle_hint_out = addr_strobe && idsel_q;

    ////////////////////////////////////////////////////////////////////////////
    // target sequencer

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            t_state <= pci_user_pkg::T_IDLE;
            stop_drive <= 1'b0;
        end else begin
            stop_drive <= user_term_in &&
                ((t_state == pci_user_pkg::T_BUSY) || (t_state == pci_user_pkg::T_DATA));
            case (t_state)
                pci_user_pkg::T_IDLE: begin
                    if (addr_strobe && (i_state == pci_user_pkg::M_IDLE) && (|hit)) begin
                        t_state <= pci_user_pkg::T_DECODE;
                    end
                end
                pci_user_pkg::T_DECODE: begin
                    t_state <= pci_user_pkg::T_BUSY;
                end
                pci_user_pkg::T_BUSY: begin
                    t_state <= pci_user_pkg::T_DATA;
                end
                pci_user_pkg::T_DATA: begin
                    if (ctrl_n_in.frame && (xfer || (stop_drive && !ctrl_n_in.irdy))) begin
                        t_state <= pci_user_pkg::T_TURN;
                    end
                end
                default: begin
                    t_state <= pci_user_pkg::T_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            base_hit_out <= pci_user_pkg::HIT_RESET;
        end else if (t_state == pci_user_pkg::T_DECODE) begin
            base_hit_out <= hit_reg;
        end else begin
            base_hit_out <= pci_user_pkg::HIT_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // initiator sequencer and parking

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            req_n_out <= 1'b1;
            parking <= 1'b0;
        end else begin
            req_n_out <= !(user_request_in && enables_in.bus_master);
            parking <= !gnt_n_in && !(user_request_in && enables_in.bus_master) && bus_idle &&
                       (i_state == pci_user_pkg::M_IDLE);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            i_state <= pci_user_pkg::M_IDLE;
            last_phase <= 1'b0;
            m_dir <= 1'b0;
            devsel_count <= pci_user_pkg::DEVSEL_COUNT_RESET;
        end else begin
            case (i_state)
                pci_user_pkg::M_IDLE: begin
                    last_phase <= 1'b0;
                    devsel_count <= pci_user_pkg::DEVSEL_COUNT_RESET;
                    if (start_ok) begin
                        i_state <= pci_user_pkg::M_ADDR;
                        m_dir <= m_wrdn_in;
                        last_phase <= user_complete_in;
                    end
                end
                pci_user_pkg::M_ADDR: begin
                    i_state <= pci_user_pkg::M_DATA;
                end
                pci_user_pkg::M_DATA: begin
                    if (ctrl_n_in.devsel &&
                        (devsel_count != pci_user_pkg::DEVSEL_WAIT_CYCLES)) begin
                        devsel_count <= devsel_count + 3'h1;
                    end
                    if (xfer && last_phase) begin
                        i_state <= pci_user_pkg::M_TURN;
                    end else if (!ctrl_n_in.stop ||
                                 (devsel_count == pci_user_pkg::DEVSEL_WAIT_CYCLES)) begin
                        if (last_phase) begin
                            i_state <= pci_user_pkg::M_TURN;
                        end
                        last_phase <= 1'b1;
                    end else if (user_complete_in) begin
                        last_phase <= 1'b1;
                    end
                end
                default: begin
                    i_state <= pci_user_pkg::M_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data strobe and outgoing data registers

    // data on internal bus or accepted
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            transfer_done_strobe_out <= 1'b0;
            ad_out <= pci_user_pkg::ADDR_RESET;
            cbe_out <= pci_user_pkg::CBE_RESET;
        end else begin
            transfer_done_strobe_out <= xfer &&
                ((t_state == pci_user_pkg::T_DATA) || (i_state == pci_user_pkg::M_DATA));
            // one cycle of pipeline: user data on the internal bus reaches the pads next clock
            ad_out <= internal_addr_data_bus_in;
            cbe_out <= parking ? pci_user_pkg::CBE_RESET : m_cbe_in;
        end
    end

    assign internal_addr_data_bus_out = ad_q;

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    logic t_drive;
    logic m_drive;

    assign t_drive = (t_state == pci_user_pkg::T_BUSY) || (t_state == pci_user_pkg::T_DATA) ||
                     (t_state == pci_user_pkg::T_TURN);
    assign m_drive = (i_state != pci_user_pkg::M_IDLE);

    always_comb begin
        ctrl_n_out = '1;
        ctrl_oe_out = '0;
        ad_oe_out = 1'b0;
        cbe_oe_out = 1'b0;
        internal_addr_data_bus_oe_out = 1'b0;
        if (!sys_rst_in) begin
            ctrl_oe_out.devsel = t_drive;
            ctrl_oe_out.trdy = t_drive;
            ctrl_oe_out.stop = t_drive;
            ctrl_n_out.devsel = (t_state == pci_user_pkg::T_TURN);
            ctrl_n_out.trdy = !((t_state == pci_user_pkg::T_DATA) && user_ready_in);
            ctrl_n_out.stop = !((t_state == pci_user_pkg::T_DATA) && stop_drive);
            ctrl_oe_out.frame = m_drive;
            ctrl_oe_out.irdy = m_drive;
            ctrl_n_out.frame = !((i_state == pci_user_pkg::M_ADDR) ||
                                 ((i_state == pci_user_pkg::M_DATA) && !last_phase));
            ctrl_n_out.irdy = !((i_state == pci_user_pkg::M_DATA) && user_ready_in);
            ad_oe_out = parking || (i_state == pci_user_pkg::M_ADDR) ||
                        ((i_state == pci_user_pkg::M_DATA) && m_dir) ||
                        ((t_state == pci_user_pkg::T_DATA) && !target_direction_out);
            cbe_oe_out = parking || (i_state == pci_user_pkg::M_ADDR) ||
                         (i_state == pci_user_pkg::M_DATA);
            // device drives adio on the address strobe and when receiving
            internal_addr_data_bus_oe_out = addr_strobe ||
                (t_drive && target_direction_out) ||
                ((i_state == pci_user_pkg::M_DATA) && !m_dir);
        end
    end

endmodule : pci_user_side

// ---- pci_user_side_sva.sv ----
// assertions on strobes, latches and bus start of pci_user_side
// assumes binding to pci_user_side, single pci clock
`timescale 1ns/1ps
module pci_user_side_sva (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // bus side
    input wire pci_user_pkg::ctrl_pins_type ctrl_n_in,
    input wire pci_user_pkg::ctrl_pins_type ctrl_oe_out,
    input wire logic perr_n_in,
    input wire logic ad_oe_out,
    input wire logic cbe_oe_out,
    input wire logic gnt_n_in,
    input wire logic req_n_out,
    input wire pci_user_pkg::enables_type enables_in,
    input wire logic user_request_in,
    // user side
    input wire logic [31:0] internal_addr_data_bus_out,
    input wire logic address_phase_strobe_out,
    input wire logic transfer_done_strobe_out,
    input wire logic config_cycle_hint_out,
    input wire logic target_direction_out,
    input wire logic [3:0] target_cmd_byte_enables_out,
    input wire logic [15:0] cmd_decode_out,
    input wire logic [31:0] latched_addr_out,
    input wire logic [7:0] base_hit_out,
    input wire pci_user_pkg::cycle_ctrl_type cycle_ctrl_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////
    sequence s_latch;
        ##1 latched_addr_out == $past(internal_addr_data_bus_out)
            && cmd_decode_out == 16'h0001 << $past(target_cmd_byte_enables_out);
    endsequence
    sequence s_hit_pulse;
        $onehot(base_hit_out) ##1 base_hit_out == 8'h00;
    endsequence
    a_strobe_after_frame: assert property ($fell(ctrl_n_in.frame) |=>
        address_phase_strobe_out)
        else $error("address strobe missing after frame");
    a_latch_addr_cmd: assert property (address_phase_strobe_out |-> s_latch)
        else $error("address or command not latched");
    a_cmd_held: assert property (!address_phase_strobe_out |=> $stable(cmd_decode_out))
        else $error("command changed outside address phase");
    a_dir_from_cmd: assert property (address_phase_strobe_out |=>
        {3'h0, target_direction_out} == ($past(target_cmd_byte_enables_out) & 4'h1))
        else $error("direction does not follow command");
    a_hit_one_pulse: assert property (base_hit_out != 8'h00 |-> s_hit_pulse)
        else $error("hit not a one clock one-hot pulse");
    a_hit_two_lines: assert property (base_hit_out[7:2] == 6'h00)
        else $error("unimplemented hit line active");
    a_cfg_with_strobe: assert property (config_cycle_hint_out |->
        address_phase_strobe_out)
        else $error("config hint without address strobe");
    a_req_master: assert property (1'b1 |=>
        req_n_out == !($past(user_request_in) && $past(enables_in.bus_master)))
        else $error("bus request not gated by master enable");
    a_done_on_xfer: assert property (transfer_done_strobe_out |->
        !$past(ctrl_n_in.irdy) && !$past(ctrl_n_in.trdy))
        else $error("data strobe without transfer");
    a_frame_start: assert property ($rose(ctrl_oe_out.frame) |-> !$past(gnt_n_in)
        && $past(user_request_in) && $past(enables_in.bus_master)
        && $past(ctrl_n_in.frame) && $past(ctrl_n_in.irdy))
        else $error("frame started without grant, request or idle bus");
    a_ctrl_copy: assert property (!$past(sys_rst_in) |->
        cycle_ctrl_out == {~$past(ctrl_n_in), ~$past(perr_n_in)})
        else $error("cycle control copy wrong");
    a_float_reset: assert property (disable iff (1'b0) sys_rst_in |->
        !ad_oe_out && !cbe_oe_out && ctrl_oe_out == 5'h00)
        else $error("outputs driven in reset");
endmodule : pci_user_side_sva

bind pci_user_side pci_user_side_sva u_sva (
    .clk_sys_in, .sys_rst_in, .ctrl_n_in, .ctrl_oe_out, .perr_n_in, .ad_oe_out,
    .cbe_oe_out, .gnt_n_in, .req_n_out, .enables_in, .user_request_in,
    .internal_addr_data_bus_out, .address_phase_strobe_out, .transfer_done_strobe_out,
    .config_cycle_hint_out, .target_direction_out, .target_cmd_byte_enables_out,
    .cmd_decode_out, .latched_addr_out, .base_hit_out, .cycle_ctrl_out
);

// ---- pci_user_side_tb.sv ----
// self-checking bench: the bench plays the other bus agent and the arbiter
// assumes pci_user_app on the user side and the bound checker
`timescale 1ns/1ps
module pci_user_side_tb;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    pci_user_pkg::ctrl_pins_type bctl, pins, dn, doe;
    pci_user_pkg::enables_type en;
    logic [31:0] bad, pad, ad_out, udata, ibus, laddr;
    logic [3:0] bcbe, pcbe, cbe_out, mcbe, tcbe;
    logic ad_oe, cbe_oe, gnt_n, req_n, idsel, perr_n, ureq, cmpl, rdy, term, strobe, done;
    logic hint, dir, ibus_oe;
    logic [15:0] cmd_dec;
    logic [7:0] hit, hv;
    logic [1:0] mode;
    int n_fail = 0;
    int n_tests = 0;
    int hits, dones;
    // pull-ups on control lines; each party drives only when enabled
    assign pins = (dn & doe) | (bctl & ~doe);
    assign pad = ad_oe ? ad_out : bad;
    assign pcbe = cbe_oe ? cbe_out : bcbe;
    always #25 clk_sys_in = ~clk_sys_in;
    pci_user_side DUT (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ctrl_n_in(pins), .ctrl_n_out(dn),
        .ctrl_oe_out(doe), .perr_n_in(perr_n), .ad_in(pad), .ad_out(ad_out), .ad_oe_out(ad_oe),
        .cbe_in(pcbe), .cbe_out(cbe_out), .cbe_oe_out(cbe_oe), .gnt_n_in(gnt_n), .req_n_out(req_n),
        .idsel_in(idsel), .enables_in(en), .mem_base_in(32'h0010_0000),
        .io_base_in(32'h0000_2000),
        .user_request_in(ureq), .user_complete_in(cmpl), .m_cbe_in(mcbe), .m_wrdn_in(mcbe[0]),
        .user_ready_in(rdy), .user_term_in(term), .internal_addr_data_bus_in(udata),
        .internal_addr_data_bus_out(ibus), .internal_addr_data_bus_oe_out(ibus_oe),
        .address_phase_strobe_out(strobe), .transfer_done_strobe_out(done),
        .config_cycle_hint_out(hint), .target_direction_out(dir),
        .target_cmd_byte_enables_out(tcbe), .cmd_decode_out(cmd_dec), .latched_addr_out(laddr),
        .base_hit_out(hit), .cycle_ctrl_out()
    );
    pci_user_app app (
        .clk_in(clk_sys_in), .rst_in(sys_rst_in), .mode_in(mode), .strobe_in(strobe),
        .cfg_read_in(cmd_dec[10]), .ready_out(rdy), .term_out(term), .bus_data_out(udata)
    );
    ////////////////////////////////////////////////////////////
    task automatic step;
        @(posedge clk_sys_in);
        #1;
    endtask : step
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    // single data phase as bus master; irdy held until trdy or stop is sampled
    task automatic master_cycle(input logic [3:0] cmd, input logic [31:0] addr);
        logic fin;
        fin = 1'b0;
        hits = 0;
        dones = 0;
        repeat (3) step;
        bctl.frame = 1'b0;
        bad = addr;
        bcbe = cmd;
        step;
        bctl.frame = 1'b1;
        bctl.irdy = 1'b0;
        bad = 32'h5a5a_0f0f;
        bcbe = 4'h0;
        chk("addr strobe", strobe, 1'b1);
        chk("cmd out", tcbe, cmd);
        chk("cfg hint", hint, idsel);
        for (int i = 0; i < 14; i++) begin
            step;
            if (fin) bctl.irdy = 1'b1;
            if (!pins.trdy || !pins.stop) fin = 1'b1;
            if (i == 0) begin
                chk("latched addr", laddr, addr);
                chk("cmd decode", cmd_dec, 32'h1 << cmd);
                chk("direction", dir, cmd[0]);
                chk("byte enables", tcbe, 4'h0);
            end
            if (hit !== 8'h00) begin
                hits++;
                hv = hit;
            end
            if (done === 1'b1) begin
                dones++;
                chk("bus drive", ibus_oe, cmd[0]);
                if (cmd[0]) chk("write data", ibus, 32'h5a5a_0f0f);
            end
        end
        bctl.irdy = 1'b1;
    endtask : master_cycle
    task automatic t_reset;
        chk("oe in reset", {ad_oe, cbe_oe, doe}, 7'h00);
        chk("req in reset", req_n, 1'b1);
    endtask : t_reset
    task automatic t_park;
        gnt_n = 1'b0;
        ureq = 1'b1;
        perr_n = 1'b0;
        step;
        perr_n = 1'b1;
        repeat (2) step;
        chk("park cbe oe", cbe_oe, 1'b1);
        chk("park cbe", cbe_out, 4'h0);
        chk("no frame", doe.frame, 1'b0);
        chk("no request", req_n, 1'b1);
        gnt_n = 1'b1;
        ureq = 1'b0;
    endtask : t_park
    task automatic t_target;
        master_cycle(pci_user_pkg::CMD_MEM_WRITE, 32'h0010_0040);
        chk("hit disabled", hits, 0);
        en.memory = 1'b1;
        master_cycle(pci_user_pkg::CMD_MEM_WRITE, 32'h0010_0040);
        chk("mem hits", hits, 1);
        chk("mem hit line", hv, 8'h01);
        chk("mem writes", dones, 1);
        en.io = 1'b1;
        mode = 2'h1;
        master_cycle(pci_user_pkg::CMD_IO_READ, 32'h0000_2004);
        chk("io hit line", hv, 8'h02);
        chk("slow read", dones, 1);
        mode = 2'h2;
        master_cycle(pci_user_pkg::CMD_MEM_READ, 32'h0010_0080);
        chk("retry claimed", hits, 1);
        chk("retry moves none", dones, 0);
        mode = 2'h0;
        idsel = 1'b1;
        master_cycle(4'ha, 32'h0000_0010);
        idsel = 1'b0;
    endtask : t_target
    task automatic t_init;
        en.bus_master = 1'b1;
        ureq = 1'b1;
        cmpl = 1'b1;
        mcbe = pci_user_pkg::CMD_MEM_WRITE;
        step;
        chk("bus request", req_n, 1'b0);
        gnt_n = 1'b0;
        for (int i = 0; i < 6 && !(doe.frame && !dn.frame); i++) step;
        chk("frame start", {doe.frame, dn.frame}, 2'b10);
        chk("command out", cbe_out, pci_user_pkg::CMD_MEM_WRITE);
        ureq = 1'b0;
        gnt_n = 1'b1;
        mcbe = 4'h0;
        step;
        chk("own strobe", strobe, 1'b1);
        bctl.devsel = 1'b0;
        bctl.trdy = 1'b0;
        dones = 0;
        for (int i = 0; i < 8; i++) begin
            step;
            if (done === 1'b1) dones++;
        end
        bctl.devsel = 1'b1;
        bctl.trdy = 1'b1;
        chk("init transfer", dones, 1);
    endtask : t_init
    ////////////////////////////////////////////////////////////
    initial begin
        bctl = 5'h1f;
        bad = 32'h0;
        bcbe = 4'h0;
        en = 3'h0;
        gnt_n = 1'b1;
        idsel = 1'b0;
        perr_n = 1'b1;
        ureq = 1'b0;
        cmpl = 1'b0;
        mcbe = 4'h0;
        mode = 2'h0;
        repeat (16) @(posedge clk_sys_in);
        #1;
        t_reset;
        sys_rst_in = 1'b0;
        t_park;
        t_target;
        t_init;
        end_sim;
    end
    initial begin
        #(50 * 4000);
        n_fail++;
        end_sim;
    end
endmodule : pci_user_side_tb
